// >>> core/scdpm_pkg.sv
// Purpose: Shared constants for the sample clock divider, delay and power-mode block
// Assumes: 8-bit registers on a 15-bit serial-port address space
// Notes: Two converter channels share one divider
package scdpm_pkg;
	localparam int NUM_CH = 2;
	localparam int CLK_HZ = 20000000;
	localparam int ADDR_W = 15;
	localparam int FRAME_BITS = 24;

	localparam logic [14:0] ADDR_CHAN_SEL = 15'h008;
	localparam logic [14:0] ADDR_PWR_MODE = 15'h03F;
	localparam logic [14:0] ADDR_PIN_CFG = 15'h040;
	localparam logic [14:0] ADDR_DIV_RATIO = 15'h10B;
	localparam logic [14:0] ADDR_HALF_DLY = 15'h10C;
	localparam logic [14:0] ADDR_DIV_SYNC = 15'h10D;
	localparam logic [14:0] ADDR_FINE_EN = 15'h117;
	localparam logic [14:0] ADDR_FINE_VAL = 15'h118;
	localparam logic [14:0] ADDR_LOW_POWER_HOLD_FUNCTION_OUT = 15'h571;

	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [7:0] CHAN_SEL_RST = 8'h03;

	// Field positions
	localparam int SYNC_EN_BIT = 7;
	localparam int FINE_EN_BIT = 0;
	localparam int HALF_DLY_BIT = 0;
	localparam int LOW_POWER_HOLD_FUNCTION_K_BIT = 7;
	localparam int PIN_FUNC_BIT = 6;
	localparam int RW_BIT = 15;

	// Power mode field in the low two bits of the power mode register
	localparam logic [1:0] PMODE_NORMAL = 2'h0;
	localparam logic [1:0] PMODE_STANDBY = 2'h2;
	localparam logic [1:0] PMODE_OFF = 2'h3;

	// Divide ratio code in the low two bits: 1, 2, 4, 8
	localparam logic [2:0] HALF_LIM_DIV1 = 3'h0;
	localparam logic [2:0] HALF_LIM_DIV2 = 3'h1;
	localparam logic [2:0] HALF_LIM_DIV4 = 3'h3;
	localparam logic [2:0] HALF_LIM_DIV8 = 3'h7;

	// Fine delay span, in femtoseconds
	localparam int FINE_MIN_FS = -151700;
	localparam int FINE_MAX_FS = 150000;
	localparam int FINE_STEP_FS = 1700;

	localparam logic [4:0] BIT_CNT_INSTR = 5'h10;
	localparam logic [4:0] BIT_CNT_LAST = 5'h17;
endpackage

// >>> core/scdpm_core.sv
// Purpose: Sample clock divider with resync, per-channel delays and power modes
// Assumes: Each clk edge stands for one half period of the converter input clock
// Notes: Registers reached over a three-wire serial port sampled on clk
`timescale 1ns/1ps
module scdpm_core (
	input wire logic clk,
	input wire logic rst,
	input wire logic sysref,
	input wire logic power_control_pin,
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_sdio_i,
	output logic spi_sdio_o,
	output logic spi_sdio_oe,
	output logic [scdpm_pkg::NUM_CH-1:0] sample_clk,
	output logic [scdpm_pkg::NUM_CH-1:0] sample_take,
	output logic [scdpm_pkg::NUM_CH-1:0] fine_delay_on,
	output logic [7:0] fine_delay_code_a,
	output logic [7:0] fine_delay_code_b,
	output logic [scdpm_pkg::NUM_CH-1:0] datapath_reset,
	output logic full_power_off_function,
	output logic low_power_hold_function,
	output logic link_run,
	output logic link_send_zero,
	output logic link_send_k
);
	import scdpm_pkg::*;

	// Serial port
	logic sclk_prev_q;
	logic sysref_prev_q;
	logic [4:0] bit_cnt_q;
	logic [FRAME_BITS-2:0] shift_q;
	logic rd_q;
	logic [7:0] rd_shift_q;
	logic sdio_o_q;
	logic sdio_oe_q;

	// Register file
	logic [7:0] chan_sel_q;
	logic [7:0] pwr_mode_q;
	logic [7:0] pin_cfg_q;
	logic [7:0] div_ratio_q;
	logic [7:0] div_sync_q;
	logic [7:0] low_power_hold_function_out_q;
	logic [7:0] half_dly_q [NUM_CH];
	logic [7:0] fine_en_q [NUM_CH];
	logic [7:0] fine_val_q [NUM_CH];

	// Divider
	logic [2:0] cnt_q;
	logic div_clk_q;
	logic div_dly_q;
	logic pend_q;
	logic [NUM_CH-1:0] samp_q;
	logic [NUM_CH-1:0] take_q;
	logic [NUM_CH-1:0] dp_rst_q;

	// Power and link
	logic pd_q;
	logic sb_q;
	logic run_q;
	logic zero_q;
	logic k_q;

	wire sclk_rise = spi_sclk & ~sclk_prev_q;
	wire sclk_fall = ~spi_sclk & sclk_prev_q;
	wire last_bit = sclk_rise && (bit_cnt_q == BIT_CNT_LAST);
	wire wr_fire = !spi_cs_n && last_bit && !shift_q[FRAME_BITS-2];
	wire [ADDR_W-1:0] wr_addr = shift_q[FRAME_BITS-3:7];
	wire [7:0] wr_data = {shift_q[6:0], spi_sdio_i};
	wire instr_done = !spi_cs_n && sclk_fall && (bit_cnt_q == BIT_CNT_INSTR);
	wire data_phase = !spi_cs_n && sclk_fall && (bit_cnt_q > BIT_CNT_INSTR) && rd_q;
	wire [ADDR_W-1:0] rd_addr = shift_q[ADDR_W-1:0];

	// Local reads come from the lowest selected channel
	wire rd_ch = ~chan_sel_q[0];

	wire wr_chan_sel = wr_fire && (wr_addr == ADDR_CHAN_SEL);
	wire wr_pwr_mode = wr_fire && (wr_addr == ADDR_PWR_MODE);
	wire wr_pin_cfg = wr_fire && (wr_addr == ADDR_PIN_CFG);
	wire wr_div_ratio = wr_fire && (wr_addr == ADDR_DIV_RATIO);
	wire wr_half_dly = wr_fire && (wr_addr == ADDR_HALF_DLY);
	wire wr_div_sync = wr_fire && (wr_addr == ADDR_DIV_SYNC);
	wire wr_fine_en = wr_fire && (wr_addr == ADDR_FINE_EN);
	wire wr_fine_val = wr_fire && (wr_addr == ADDR_FINE_VAL);
	wire wr_low_power_hold_function_out = wr_fire && (wr_addr == ADDR_LOW_POWER_HOLD_FUNCTION_OUT);

	wire [7:0] rd_data =
		(rd_addr == ADDR_CHAN_SEL) ? chan_sel_q :
		(rd_addr == ADDR_PWR_MODE) ? pwr_mode_q :
		(rd_addr == ADDR_PIN_CFG) ? pin_cfg_q :
		(rd_addr == ADDR_DIV_RATIO) ? div_ratio_q :
		(rd_addr == ADDR_HALF_DLY) ? half_dly_q[rd_ch] :
		(rd_addr == ADDR_DIV_SYNC) ? div_sync_q :
		(rd_addr == ADDR_FINE_EN) ? fine_en_q[rd_ch] :
		(rd_addr == ADDR_FINE_VAL) ? fine_val_q[rd_ch] :
		(rd_addr == ADDR_LOW_POWER_HOLD_FUNCTION_OUT) ? low_power_hold_function_out_q : REG_RST;

	// Half-phase limit per ratio; a toggle every limit+1 half periods keeps 50% duty
	wire [2:0] half_lim =
		(div_ratio_q[1:0] == 2'h0) ? HALF_LIM_DIV1 :
		(div_ratio_q[1:0] == 2'h1) ? HALF_LIM_DIV2 :
		(div_ratio_q[1:0] == 2'h2) ? HALF_LIM_DIV4 : HALF_LIM_DIV8;
	wire phase_end = (cnt_q >= half_lim);

	wire sync_evt = div_sync_q[SYNC_EN_BIT] && sysref && !sysref_prev_q;
	// A new ratio restarts the divider the same way a sync event does
	wire restart_evt = sync_evt || wr_div_ratio;

	wire pin_as_standby = pin_cfg_q[PIN_FUNC_BIT];
	wire pd_req = (pwr_mode_q[1:0] == PMODE_OFF) ||
		(power_control_pin && !pin_as_standby);
	wire sb_req = !pd_req && ((pwr_mode_q[1:0] == PMODE_STANDBY) ||
		(power_control_pin && pin_as_standby));

	always_ff @(posedge clk) begin
		if (rst) begin
			sclk_prev_q <= 1'b0;
			sysref_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= spi_sclk;
			sysref_prev_q <= sysref;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || spi_cs_n) begin
			bit_cnt_q <= 5'h00;
			shift_q <= '0;
		end else if (sclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			shift_q <= {shift_q[FRAME_BITS-3:0], spi_sdio_i};
		end
	end

	// Read data leaves on falling sclk so the host can sample it on the rising edge
	always_ff @(posedge clk) begin
		if (rst || spi_cs_n) begin
			rd_q <= 1'b0;
			rd_shift_q <= 8'h00;
			sdio_o_q <= 1'b0;
			sdio_oe_q <= 1'b0;
		end else if (instr_done) begin
			rd_q <= shift_q[RW_BIT];
			rd_shift_q <= {rd_data[6:0], 1'b0};
			sdio_o_q <= rd_data[7];
			sdio_oe_q <= shift_q[RW_BIT];
		end else if (data_phase) begin
			rd_shift_q <= {rd_shift_q[6:0], 1'b0};
			sdio_o_q <= rd_shift_q[7];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chan_sel_q <= CHAN_SEL_RST;
			pwr_mode_q <= REG_RST;
			pin_cfg_q <= REG_RST;
			div_ratio_q <= REG_RST;
			div_sync_q <= REG_RST;
			low_power_hold_function_out_q <= REG_RST;
		end else begin
			if (wr_chan_sel)
				chan_sel_q <= wr_data;
			if (wr_pwr_mode)
				pwr_mode_q <= wr_data;
			if (wr_pin_cfg)
				pin_cfg_q <= wr_data;
			if (wr_div_ratio)
				div_ratio_q <= wr_data;
			if (wr_div_sync)
				div_sync_q <= wr_data;
			if (wr_low_power_hold_function_out)
				low_power_hold_function_out_q <= wr_data;
		end
	end

	// Restart only while low, so a sync never cuts the high phase in flight short; a new ratio applies to it at once
	always_ff @(posedge clk) begin
		if (rst || pd_req) begin
			cnt_q <= 3'h0;
			div_clk_q <= 1'b0;
			pend_q <= 1'b0;
		end else if ((restart_evt || pend_q) && !div_clk_q) begin
			cnt_q <= 3'h0;
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_q || restart_evt;
			if (phase_end) begin
				cnt_q <= 3'h0;
				div_clk_q <= ~div_clk_q;
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			div_dly_q <= 1'b0;
		else
			div_dly_q <= div_clk_q;
	end

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			wire sel = chan_sel_q[ch];
			wire fine_rise = wr_fine_en && sel && wr_data[FINE_EN_BIT] &&
				!fine_en_q[ch][FINE_EN_BIT];
			wire samp_d = half_dly_q[ch][HALF_DLY_BIT] ? div_dly_q : div_clk_q;

			always_ff @(posedge clk) begin
				if (rst) begin
					half_dly_q[ch] <= REG_RST;
					fine_en_q[ch] <= REG_RST;
					fine_val_q[ch] <= REG_RST;
				end else begin
					if (wr_half_dly && sel)
						half_dly_q[ch] <= wr_data;
					if (wr_fine_en && sel)
						fine_en_q[ch] <= wr_data;
					if (wr_fine_val && sel)
						fine_val_q[ch] <= wr_data;
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					samp_q[ch] <= 1'b0;
					take_q[ch] <= 1'b0;
					dp_rst_q[ch] <= 1'b0;
				end else begin
					samp_q[ch] <= samp_d;
					take_q[ch] <= samp_d && !samp_q[ch];
					dp_rst_q[ch] <= fine_rise;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (rst) begin
			pd_q <= 1'b0;
			sb_q <= 1'b0;
			run_q <= 1'b0;
			zero_q <= 1'b0;
			k_q <= 1'b0;
		end else begin
			pd_q <= pd_req;
			sb_q <= sb_req;
			run_q <= !pd_req;
			zero_q <= sb_req && !low_power_hold_function_out_q[LOW_POWER_HOLD_FUNCTION_K_BIT];
			k_q <= sb_req && low_power_hold_function_out_q[LOW_POWER_HOLD_FUNCTION_K_BIT];
		end
	end

	assign spi_sdio_o = sdio_o_q;
	assign spi_sdio_oe = sdio_oe_q;
	assign sample_clk = samp_q;
	assign sample_take = take_q;
	// Enable and code are live flops: no trigger is needed to apply them
	assign fine_delay_on = {fine_en_q[1][FINE_EN_BIT], fine_en_q[0][FINE_EN_BIT]};
	// Code maps to the analog delay line: code times the step from the negative end
	assign fine_delay_code_a = fine_val_q[0];
	assign fine_delay_code_b = fine_val_q[1];
	assign datapath_reset = dp_rst_q;
	assign full_power_off_function = pd_q;
	assign low_power_hold_function = sb_q;
	assign link_run = run_q;
	assign link_send_zero = zero_q;
	assign link_send_k = k_q;
endmodule

// >>> verif/scdpm_chk.sv
// Purpose: Port checks for the sample clock divider and power-mode block
// Assumes: One clock, synchronous reset; ratio is not decoded from the serial port
// Notes: High phase is checked against the legal set since the ratio is hidden
`timescale 1ns/1ps
module scdpm_chk import scdpm_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic spi_cs_n,
	input wire logic [NUM_CH-1:0] sample_clk,
	input wire logic [NUM_CH-1:0] sample_take,
	input wire logic [NUM_CH-1:0] fine_delay_on,
	input wire logic [7:0] fine_delay_code_b,
	input wire logic [NUM_CH-1:0] datapath_reset,
	input wire logic full_power_off_function,
	input wire logic low_power_hold_function,
	input wire logic link_run,
	input wire logic link_send_zero,
	input wire logic link_send_k
);
	logic [3:0] hi_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Length of the current high phase of channel A
	always_ff @(posedge clk) begin
		if (rst || !sample_clk[0]) begin
			hi_q <= 4'h0;
		end else begin
			hi_q <= hi_q + 4'h1;
		end
	end
	// The take flop is fed from the same select as the clock, so it pulses with the rise
	chk_take_after_rise: assert property ($rose(sample_clk[0]) |-> sample_take[0])
		else $error("take pulse missing after sample clock rise");
	chk_take_has_cause: assert property (sample_take[1] |->
		sample_clk[1] && !$past(sample_clk[1]))
		else $error("take pulse without a preceding rise");
	// Power-off stops the divider at once; only restarts must keep whole phases
	chk_high_phase_legal: assert property ($fell(sample_clk[0]) && !full_power_off_function |->
		hi_q inside {4'h1, 4'h2, 4'h4, 4'h8})
		else $error("high phase length not a legal ratio");
	chk_off_clock_low: assert property (full_power_off_function [*4] |-> sample_clk == '0)
		else $error("sample clock running in power-off");
	chk_off_link_down: assert property (full_power_off_function |->
		!link_run && !low_power_hold_function)
		else $error("link running in power-off");
	chk_hold_link_up: assert property (low_power_hold_function |->
		link_run && (link_send_zero != link_send_k))
		else $error("standby fill selection wrong");
	chk_fill_only_hold: assert property ((link_send_zero || link_send_k) |->
		low_power_hold_function)
		else $error("fill selected outside standby");
	chk_enable_resets_dp: assert property ($rose(fine_delay_on[1]) |->
		($past(datapath_reset[1]) || datapath_reset[1]) or (##1 datapath_reset[1]))
		else $error("no datapath reset on fine delay enable");
	chk_dp_one_cycle: assert property (datapath_reset[1] |=> !datapath_reset[1])
		else $error("datapath reset longer than one cycle");
	chk_code_by_frame: assert property (!$stable(fine_delay_code_b) |-> !$past(spi_cs_n))
		else $error("fine code changed outside a frame");
	cov_dp_reset: cover property ($rose(datapath_reset[1]));
	cov_hold_k: cover property (low_power_hold_function && link_send_k);
	cov_div8: cover property ($fell(sample_clk[0]) && hi_q == 4'h8);
endmodule

// >>> verif/scdpm_host.sv
// Purpose: Serial configuration host driving the block's three-wire port
// Assumes: Serial clock idles low; each serial phase lasts two system clocks
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module scdpm_host (
	input wire logic clk,
	input wire logic spi_sdio_o,
	input wire logic spi_sdio_oe,
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_sdio_i
);
	logic drv_q = 1'b1;
	logic dat_q = 1'b0;
	// A stale bit must never pass for read data
	assign spi_sdio_i = spi_sdio_oe ? spi_sdio_o : (drv_q ? dat_q : !dat_q);
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
		output logic [7:0] q);
		logic [23:0] f;
		f = {rd, a, wd};
		q = 8'h00;
		@(posedge clk);
		spi_cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			@(posedge clk);
			spi_sclk <= 1'b0;
			dat_q <= f[i];
			drv_q <= !(rd && i < 8);
			repeat (2) @(posedge clk);
			spi_sclk <= 1'b1;
			@(posedge clk);
			@(negedge clk);
			if (i < 8) q[i] = spi_sdio_i;
		end
		@(posedge clk);
		spi_sclk <= 1'b0;
		repeat (2) @(posedge clk);
		spi_cs_n <= 1'b1;
		drv_q <= 1'b1;
		repeat (2) @(posedge clk);
	endtask
endmodule

// >>> verif/scdpm_core_test.sv
// Purpose: Self-checking bench for the sample clock divider block
// Assumes: 50 ns clock; registers reached only through the serial host
// Notes: Ratio and sync are judged by counting divided clock phases
`timescale 1ns/1ps
module scdpm_core_test;
	import scdpm_pkg::*;
	logic clk, rst, pin, sysref, cs_n, sclk, sdi, sdo, oe, off, hold, run, zero, kch, p;
	logic [1:0] sck, take, fon, dpr;
	logic [7:0] ca, cb, rd;
	int errors = 0;
	int cmp_count = 0;
	int dp_cnt = 0;
	int h, d[2];
	logic [7:0] pwi[6] = '{8'h80, 8'hC0, 8'hE0, 8'h23, 8'h02, 8'h00};
	logic [4:0] pwe[6] = '{5'h10, 5'h0E, 5'h0D, 5'h10, 5'h0E, 5'h04};
	scdpm_core DUT (.clk(clk), .rst(rst), .sysref(sysref), .power_control_pin(pin),
		.spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdio_i(sdi), .spi_sdio_o(sdo),
		.spi_sdio_oe(oe), .sample_clk(sck), .sample_take(take), .fine_delay_on(fon),
		.fine_delay_code_a(ca), .fine_delay_code_b(cb), .datapath_reset(dpr),
		.full_power_off_function(off), .low_power_hold_function(hold), .link_run(run),
		.link_send_zero(zero), .link_send_k(kch));
	scdpm_host host (.clk(clk), .spi_sdio_o(sdo), .spi_sdio_oe(oe), .spi_cs_n(cs_n),
		.spi_sclk(sclk), .spi_sdio_i(sdi));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (dpr[1] === 1'b1) dp_cnt++;
	task automatic compare(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic final_report();
		$display("comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] v);
		host.xfer(1'b0, a, v, rd);
	endtask
	task automatic rdc(input logic [14:0] a, input logic [7:0] exp);
		host.xfer(1'b1, a, 8'h00, rd);
		compare("register read", exp, rd);
	endtask
	// Bounded wait for a level on channel A; n is the cycles it took
	task automatic wait_sck(input logic v, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sck[0] !== v && n < 200);
		if (n >= 200) begin
			errors++;
			final_report();
		end
	endtask
	initial begin
		rst = 1'b1;
		pin = 1'b0;
		sysref = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc(ADDR_CHAN_SEL, CHAN_SEL_RST);
		rdc(ADDR_DIV_SYNC, REG_RST);
		rdc(15'h7FF, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_DIV_RATIO, 8'(c));
			// Skip a high phase still in flight from the old ratio
			wait_sck(1'b0, h);
			wait_sck(1'b1, h);
			wait_sck(1'b0, h);
			compare("high phase", 8'(1 << c), 8'(h));
			wait_sck(1'b1, h);
			compare("low phase", 8'(1 << c), 8'(h));
		end
		// Delay goes on channel B: a phase stretched at the switch stays off watched channel A
		wr(ADDR_CHAN_SEL, 8'h02);
		wr(ADDR_HALF_DLY, 8'h01);
		h = 0;
		@(negedge clk);
		p = sck[0];
		repeat (32) begin
			@(negedge clk);
			if (sck[1] !== p) h++;
			p = sck[0];
		end
		compare("half delay lag", 8'h00, 8'(h));
		compare("link kept", 8'h01, {7'h00, run});
		wr(ADDR_CHAN_SEL, 8'h01);
		rdc(ADDR_HALF_DLY, 8'h00);
		wr(ADDR_CHAN_SEL, 8'h02);
		rdc(ADDR_HALF_DLY, 8'h01);
		wr(ADDR_FINE_VAL, 8'h5A);
		compare("fine code b", 8'h5A, cb);
		compare("fine code a", 8'h00, ca);
		wr(ADDR_FINE_EN, 8'h01);
		compare("fine enable", 8'h02, {6'h00, fon});
		wr(ADDR_FINE_EN, 8'h01);
		compare("datapath resets", 8'h01, 8'(dp_cnt));
		wr(ADDR_FINE_VAL, 8'hFF);
		compare("fine code b", 8'hFF, cb);
		compare("link kept", 8'h01, {7'h00, run});
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_DIV_SYNC, s ? 8'h80 : 8'h00);
			for (int j = 0; j < 2; j++) begin
				wait_sck(1'b1, h);
				wait_sck(1'b0, h);
				repeat (1 + 2 * j) @(posedge clk);
				sysref <= 1'b1;
				@(posedge clk);
				sysref <= 1'b0;
				wait_sck(1'b1, d[j]);
			end
			compare("sync alignment", 8'(s), 8'(d[0] == d[1]));
		end
		foreach (pwi[r]) begin
			pin <= pwi[r][7];
			wr(ADDR_PIN_CFG, {1'b0, pwi[r][6], 6'h00});
			wr(ADDR_LOW_POWER_HOLD_FUNCTION_OUT, {pwi[r][5], 7'h00});
			wr(ADDR_PWR_MODE, {6'h00, pwi[r][1:0]});
			compare("power outputs", {3'h0, pwe[r]}, {3'h0, off, hold, run, zero, kch});
		end
		final_report();
	end
endmodule
bind scdpm_core scdpm_chk u_chk (.clk, .rst, .spi_cs_n, .sample_clk, .sample_take,
	.fine_delay_on, .fine_delay_code_b, .datapath_reset, .full_power_off_function,
	.low_power_hold_function, .link_run, .link_send_zero, .link_send_k);
